// ---- inc/srf_defs.svh ----
`ifndef SRF_DEFS_SVH
`define SRF_DEFS_SVH
// ****************************************
// Address decode limits
// ****************************************
`define SRF_MOD_FIRST   4'h8
`define SRF_DST_DIRECT  5'h08
`define SRF_SRC_DIRECT  5'h10
// ****************************************
// Register addresses {module, subindex}
// ****************************************
`define SRF_A_AP        8'h80
`define SRF_A_APC       8'h81
`define SRF_A_ACCESS_RIGHTS      8'h82
`define SRF_A_RIGHTS_MASK_STAGE    8'h83
`define SRF_A_PSF       8'h84
`define SRF_A_IC        8'h85
`define SRF_A_RIGHTS_MASK_COMMIT    8'h86
`define SRF_A_SC        8'h88
`define SRF_A_VECTOR_PRIORITY_LOW      8'h89
`define SRF_A_VECTOR_PRIORITY_HIGH      8'h8a
`define SRF_A_RIGHTS_FAULT_FLAGS     8'h8b
`define SRF_A_LOADER_REGION_BOUND      8'h8c
`define SRF_A_APPLICATION_REGION_BOUND      8'h8d
`define SRF_A_CLOCK_DIVIDE_CONTROL      8'h8e
`define SRF_A_WATCHDOG_CONTROL      8'h8f
`define SRF_MOD_ACC     4'h9
`define SRF_A_ACC       8'ha0
`define SRF_A_ACC_AP    8'ha1
`define SRF_MOD_PFX     4'hb
`define SRF_A_IP        8'hc0
`define SRF_A_SP        8'hd1
`define SRF_A_IV        8'hd2
`define SRF_A_LC0       8'hd6
`define SRF_A_LC1       8'hd7
`define SRF_A_OFFS      8'he3
`define SRF_A_DPC       8'he4
`define SRF_A_GR        8'he5
`define SRF_A_GRL       8'he6
`define SRF_A_BP        8'he7
`define SRF_A_GRS       8'he8
`define SRF_A_GRH       8'he9
`define SRF_A_GENERAL_SIGN_EXTENDED      8'hea
`define SRF_A_FP        8'heb
`define SRF_A_DP0       8'hf3
`define SRF_A_DP1       8'hf7
`define SRF_A_CP        8'hfb
// ****************************************
// Field positions
// ****************************************
`define SRF_APC_CLR     7
`define SRF_APC_DIR     6
`define SRF_APC_MOD_HI  2
`define SRF_PSF_RW_HI   4
`define SRF_RIGHTS_FAULT_FLAGS_LO    4
// ****************************************
// Reset values, write masks, static masks
// ****************************************
`define SRF_MODULUS_OFF 3'h0
`define SRF_ACCESS_RIGHTS_RST    4'hf
`define SRF_IPS_RST     2'h3
`define SRF_SC_RST      16'h0480
`define SRF_SC_POR      16'h0782
`define SRF_SC_STATIC   16'h0302
`define SRF_SC_WMASK    16'h07be
`define SRF_CK_STATIC   16'h00e0
`define SRF_CK_WMASK    8'h1f
`define SRF_WD_STATIC   16'h00c6
`define SRF_BOUND_RST   9'h080
`define SRF_IP_RST      16'h8000
`define SRF_SP_RST      10'h3f0
`define SRF_IV_RST      16'h0020
`define SRF_DPC_RST     7'h5c
`endif

// ---- inc/srf_pkg.sv ----
package srf_pkg;
  // Register move destination from the decoder
  typedef struct packed {
    logic        vld;
    logic [3:0]  mod;
    logic [4:0]  idx;
    logic        prefix_slots;
    logic        from_acc;
    logic [15:0] data;
  } srf_dst_t;
  // Register move source request
  typedef struct packed {
    logic       vld;
    logic [3:0] mod;
    logic [4:0] idx;
    logic       prefix_slots;
  } srf_src_t;
  // Source read answer
  typedef struct packed {
    logic        vld;
    logic [15:0] data;
  } srf_rsp_t;
  // Arithmetic or logic operation completion
  typedef struct packed {
    logic        done;
    logic        wr;
    logic [15:0] res;
  } srf_alu_t;
  // Pointer update choice
  typedef enum logic [3:0] {
    SRF_HOLD  = 4'b0001,
    SRF_LOAD  = 4'b0010,
    SRF_STEP  = 4'b0100,
    SRF_CLEAR = 4'b1000
  } srf_ptr_op_t;
endpackage

// ---- rtl/srf_acc_bank.sv ----
`timescale 1ns/1ps
`include "srf_defs.svh"
module srf_acc_bank #(
  parameter int N = 16,
  parameter int W = 16
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 wr_en,
  input  wire logic [$clog2(N)-1:0] wr_idx,
  input  wire logic [W-1:0]         wr_data,
  input  wire logic [$clog2(N)-1:0] rd_idx,
  input  wire logic [$clog2(N)-1:0] act_idx,
  output logic      [W-1:0]         rd_data,
  output logic      [W-1:0]         act_data
);
  import srf_pkg::*;
  localparam int AW = $clog2(N);
  logic [W-1:0] acc_r [N];
  // One accumulator per slot, cleared on every reset
  for (genvar g = 0; g < N; g++)
  begin : g_acc
    always_ff @(posedge mclk)
    begin
      if (rst)
        acc_r[g] <= '0;
      else if (wr_en && (wr_idx == AW'(g)))
        acc_r[g] <= wr_data;
    end
  end
  // Direct and working accumulator reads
  assign rd_data  = acc_r[rd_idx];
  assign act_data = acc_r[act_idx];
endmodule

// ---- rtl/srf_ptr.sv ----
`timescale 1ns/1ps
`include "srf_defs.svh"
module srf_ptr (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ap_wr,
  input  wire logic       ap_from_acc,
  input  wire logic [3:0] ap_data,
  input  wire logic       apc_wr,
  input  wire logic [7:0] apc_data,
  input  wire logic       op_done,
  output logic      [3:0] ap_r,
  output logic      [2:0] mod_r,
  output logic            dir_r
);
  import srf_pkg::*;
  srf_ptr_op_t op;
  logic [3:0]  mask;
  logic [3:0]  stepped;
  // Width of the stepped field from the modulus
  always_comb
  begin
    case (mod_r)
      3'h0:    mask = 4'h0;
      3'h1:    mask = 4'h1;
      3'h2:    mask = 4'h3;
      3'h3:    mask = 4'h7;
      default: mask = 4'hf;
    endcase
  end
  // Wrap inside the field, keep the bits above it
  assign stepped = (ap_r & ~mask) | ((dir_r ? ap_r - 4'h1 : ap_r + 4'h1) & mask);
  // Update priority: clear, move, operation step
  always_comb
  begin
    if (apc_wr && apc_data[`SRF_APC_CLR])
      op = SRF_CLEAR;
    else if (ap_wr && ap_from_acc && (mod_r != `SRF_MODULUS_OFF))
      op = SRF_STEP;
    else if (ap_wr)
      op = SRF_LOAD;
    else if (op_done && (mod_r != `SRF_MODULUS_OFF))
      op = SRF_STEP;
    else
      op = SRF_HOLD;
  end
  // Pointer register
  always_ff @(posedge mclk)
  begin
    if (rst)
      ap_r <= 4'h0;
    else
    begin
      case (op)
        SRF_CLEAR: ap_r <= 4'h0;
        SRF_STEP:  ap_r <= stepped;
        SRF_LOAD:  ap_r <= ap_data;
        SRF_HOLD:  ap_r <= ap_r;
        default:   ap_r <= ap_r;
      endcase
    end
  end
  // Control register, clear bit is not stored
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mod_r <= 3'h0;
      dir_r <= 1'b0;
    end
    else if (apc_wr)
    begin
      mod_r <= apc_data[`SRF_APC_MOD_HI:0];
      dir_r <= apc_data[`SRF_APC_DIR];
    end
  end
endmodule

// ---- rtl/srf_top.sv ----
`timescale 1ns/1ps
`include "srf_defs.svh"
module srf_top #(
  parameter logic [8:0] BOUND_RST = `SRF_BOUND_RST
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             por,
  input  srf_pkg::srf_dst_t     dst,
  input  srf_pkg::srf_src_t     src,
  input  srf_pkg::srf_alu_t     alu,
  output srf_pkg::srf_rsp_t     rsp_r,
  output logic      [3:0]       ap_o,
  output logic      [15:0]      acc_r
);
  import srf_pkg::*;
  // ****************************************
  // Decode and reset helpers
  // ****************************************
  // Subindex reachable with or without the prefix
  function automatic logic idx_legal(input logic [4:0] idx, input logic prefix_slots,
                                     input logic [4:0] lim);
    idx_legal = (idx < lim) || prefix_slots;
  endfunction
  // Static bits survive unless the reset is power-on
  function automatic logic [15:0] keep_static(input logic [15:0] cur, input logic [15:0] rv,
                                              input logic [15:0] sm, input logic [15:0] pv,
                                              input logic pwr);
    keep_static = pwr ? pv : ((cur & sm) | (rv & ~sm));
  endfunction
  logic [7:0]  wa;
  logic [7:0]  ra;
  logic        wr_ok;
  logic        rd_ok;
  logic [15:0] wd;
  logic [15:0] rd_nxt;
  logic [3:0]  ap_w;
  logic [2:0]  mod_w;
  logic        dir_w;
  logic [15:0] acc_rd;
  logic [15:0] acc_act;
  logic        acc_wr;
  logic [3:0]  acc_widx;
  logic [15:0] acc_wdata;
  logic [3:0]  access_rights_r;
  logic [3:0]  rights_mask_stage_r;
  logic [4:0]  psf_r;
  logic        ige_r;
  logic [1:0]  ips_r;
  logic [15:0] sc_r;
  logic [15:0] vector_priority_low_r;
  logic [15:0] vector_priority_high_r;
  logic [3:0]  rights_fault_flags_r;
  logic [8:0]  loader_region_bound_r;
  logic [8:0]  application_region_bound_r;
  logic [7:0]  clock_divide_control_r;
  logic [7:0]  watchdog_control_r;
  logic [15:0] ck_keep;
  logic [15:0] wd_keep;
  logic [15:0] pfx_r [8];
  logic [15:0] ip_r;
  logic [9:0]  sp_r;
  logic [15:0] iv_r;
  logic [15:0] lc0_r;
  logic [15:0] lc1_r;
  logic [7:0]  offs_r;
  logic [6:0]  dpc_r;
  logic [7:0]  grl_r;
  logic [7:0]  grh_r;
  logic [15:0] bp_r;
  logic [15:0] dp0_r;
  logic [15:0] dp1_r;
  logic [15:0] cp_r;
  // ****************************************
  // Address decode
  // ****************************************
  // Only system modules with subindex below 10h map
  assign wa    = {dst.mod, dst.idx[3:0]};
  assign ra    = {src.mod, src.idx[3:0]};
  assign wd    = dst.data;
  assign wr_ok = dst.vld && (dst.mod >= `SRF_MOD_FIRST) && !dst.idx[4]
                 && idx_legal(dst.idx, dst.prefix_slots, `SRF_DST_DIRECT);
  assign rd_ok = src.vld && (src.mod >= `SRF_MOD_FIRST) && !src.idx[4]
                 && idx_legal(src.idx, src.prefix_slots, `SRF_SRC_DIRECT);
  // ****************************************
  // Accumulator pointer and bank
  // ****************************************
  srf_ptr u_ptr (
    .mclk        (mclk),
    .rst         (rst),
    .ap_wr       (wr_ok && (wa == `SRF_A_AP)),
    .ap_from_acc (dst.from_acc),
    .ap_data     (wd[3:0]),
    .apc_wr      (wr_ok && (wa == `SRF_A_APC)),
    .apc_data    (wd[7:0]),
    .op_done     (alu.done),
    .ap_r        (ap_w),
    .mod_r       (mod_w),
    .dir_r       (dir_w)
  );
  assign ap_o = ap_w;
  // Move writes win over a result write in the same cycle
  always_comb
  begin
    acc_wr    = 1'b0;
    acc_widx  = ap_w;
    acc_wdata = wd;
    if (wr_ok && (dst.mod == `SRF_MOD_ACC))
    begin
      acc_wr   = 1'b1;
      acc_widx = dst.idx[3:0];
    end
    else if (wr_ok && ((wa == `SRF_A_ACC) || (wa == `SRF_A_ACC_AP)))
      acc_wr = 1'b1;
    else if (alu.done && alu.wr)
    begin
      acc_wr    = 1'b1;
      acc_wdata = alu.res;
    end
  end
  srf_acc_bank #(
    .N (16),
    .W (16)
  ) u_bank (
    .mclk     (mclk),
    .rst      (rst),
    .wr_en    (acc_wr),
    .wr_idx   (acc_widx),
    .wr_data  (acc_wdata),
    .rd_idx   (src.idx[3:0]),
    .act_idx  (ap_w),
    .rd_data  (acc_rd),
    .act_data (acc_act)
  );
  // Registered copy of the working accumulator
  always_ff @(posedge mclk)
  begin
    if (rst)
      acc_r <= 16'h0000;
    else
      acc_r <= acc_act;
  end
  // ****************************************
  // Privilege, flags, interrupt control
  // ****************************************
  // Atomic privilege update through the mask stage
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      access_rights_r   <= `SRF_ACCESS_RIGHTS_RST;
      rights_mask_stage_r <= 4'h0;
    end
    else if (wr_ok && (wa == `SRF_A_ACCESS_RIGHTS))
    begin
      access_rights_r   <= wd[3:0];
      rights_mask_stage_r <= 4'h0;
    end
    else if (wr_ok && (wa == `SRF_A_RIGHTS_MASK_COMMIT))
    begin
      access_rights_r   <= rights_mask_stage_r & wd[3:0];
      rights_mask_stage_r <= 4'h0;
    end
    else if (wr_ok && (wa == `SRF_A_RIGHTS_MASK_STAGE))
      rights_mask_stage_r <= wd[3:0];
  end
  // Writable flags, interrupt enable and fault flags
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      psf_r   <= 5'h00;
      ige_r   <= 1'b0;
      ips_r   <= `SRF_IPS_RST;
      rights_fault_flags_r <= 4'h0;
    end
    else
    begin
      if (wr_ok && (wa == `SRF_A_PSF))
        psf_r <= wd[`SRF_PSF_RW_HI:0];
      if (wr_ok && (wa == `SRF_A_IC))
        ige_r <= wd[0];
      if (wr_ok && (wa == `SRF_A_RIGHTS_FAULT_FLAGS))
        rights_fault_flags_r <= wd[`SRF_RIGHTS_FAULT_FLAGS_LO+3:`SRF_RIGHTS_FAULT_FLAGS_LO];
    end
  end
  // ****************************************
  // Control registers with static bits
  // ****************************************
  // Reset images of the byte-wide controls
  assign ck_keep = keep_static({8'h00, clock_divide_control_r}, 16'h0000, `SRF_CK_STATIC, 16'h0000, por);
  assign wd_keep = keep_static({8'h00, watchdog_control_r}, 16'h0000, `SRF_WD_STATIC, 16'h0000, por);
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sc_r   <= keep_static(sc_r, `SRF_SC_RST, `SRF_SC_STATIC, `SRF_SC_POR, por);
      clock_divide_control_r <= ck_keep[7:0];
      watchdog_control_r <= wd_keep[7:0];
    end
    else
    begin
      if (wr_ok && (wa == `SRF_A_SC))
        sc_r <= wd & `SRF_SC_WMASK;
      if (wr_ok && (wa == `SRF_A_CLOCK_DIVIDE_CONTROL))
        clock_divide_control_r <= (clock_divide_control_r & ~`SRF_CK_WMASK) | (wd[7:0] & `SRF_CK_WMASK);
      if (wr_ok && (wa == `SRF_A_WATCHDOG_CONTROL))
        watchdog_control_r <= wd[7:0];
    end
  end
  // Priorities and memory region bounds
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      vector_priority_low_r <= 16'h0000;
      vector_priority_high_r <= 16'h0000;
      loader_region_bound_r <= BOUND_RST;
      application_region_bound_r <= BOUND_RST;
    end
    else
    begin
      if (wr_ok && (wa == `SRF_A_VECTOR_PRIORITY_LOW))
        vector_priority_low_r <= wd;
      if (wr_ok && (wa == `SRF_A_VECTOR_PRIORITY_HIGH))
        vector_priority_high_r <= wd;
      if (wr_ok && (wa == `SRF_A_LOADER_REGION_BOUND))
        loader_region_bound_r <= wd[8:0];
      if (wr_ok && (wa == `SRF_A_APPLICATION_REGION_BOUND))
        application_region_bound_r <= wd[8:0];
    end
  end
  // ****************************************
  // Prefix slots and program flow
  // ****************************************
  for (genvar g = 0; g < 8; g++)
  begin : g_pfx
    always_ff @(posedge mclk)
    begin
      if (rst)
        pfx_r[g] <= 16'h0000;
      else if (wr_ok && (dst.mod == `SRF_MOD_PFX) && (dst.idx[2:0] == 3'(g)))
        pfx_r[g] <= wd;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ip_r  <= `SRF_IP_RST;
      sp_r  <= `SRF_SP_RST;
      iv_r  <= `SRF_IV_RST;
      lc0_r <= 16'h0000;
      lc1_r <= 16'h0000;
    end
    else
    begin
      if (wr_ok && (wa == `SRF_A_IP))
        ip_r <= wd;
      if (wr_ok && (wa == `SRF_A_SP))
        sp_r <= wd[9:0];
      if (wr_ok && (wa == `SRF_A_IV))
        iv_r <= wd;
      if (wr_ok && (wa == `SRF_A_LC0))
        lc0_r <= wd;
      if (wr_ok && (wa == `SRF_A_LC1))
        lc1_r <= wd;
    end
  end
  // ****************************************
  // Data pointers and general register
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      offs_r <= 8'h00;
      dpc_r  <= `SRF_DPC_RST;
      bp_r   <= 16'h0000;
      dp0_r  <= 16'h0000;
      dp1_r  <= 16'h0000;
      cp_r   <= 16'h0000;
    end
    else
    begin
      if (wr_ok && (wa == `SRF_A_OFFS))
        offs_r <= wd[7:0];
      if (wr_ok && (wa == `SRF_A_DPC))
        dpc_r <= wd[6:0];
      if (wr_ok && (wa == `SRF_A_BP))
        bp_r <= wd;
      if (wr_ok && (wa == `SRF_A_DP0))
        dp0_r <= wd;
      if (wr_ok && (wa == `SRF_A_DP1))
        dp1_r <= wd;
      if (wr_ok && (wa == `SRF_A_CP))
        cp_r <= wd;
    end
  end
  // Word and byte views of the general register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      grl_r <= 8'h00;
      grh_r <= 8'h00;
    end
    else if (wr_ok && (wa == `SRF_A_GR))
    begin
      grl_r <= wd[7:0];
      grh_r <= wd[15:8];
    end
    else
    begin
      if (wr_ok && (wa == `SRF_A_GRL))
        grl_r <= wd[7:0];
      if (wr_ok && (wa == `SRF_A_GRH))
        grh_r <= wd[7:0];
    end
  end
  // ****************************************
  // Source read mux and answer
  // ****************************************
  always_comb
  begin
    rd_nxt = 16'h0000;
    if (src.mod == `SRF_MOD_ACC)
      rd_nxt = acc_rd;
    else if (src.mod == `SRF_MOD_PFX)
      rd_nxt = src.idx[3] ? 16'h0000 : pfx_r[src.idx[2:0]];
    else
    begin
      case (ra)
        `SRF_A_AP:     rd_nxt = {12'h000, ap_w};
        `SRF_A_APC:    rd_nxt = {8'h00, 1'b0, dir_w, 3'h0, mod_w};
        `SRF_A_ACCESS_RIGHTS:   rd_nxt = {12'h000, access_rights_r};
        `SRF_A_RIGHTS_MASK_STAGE: rd_nxt = {12'h000, rights_mask_stage_r};
        `SRF_A_PSF:    rd_nxt = {8'h00, acc_act == 16'h0000, acc_act[15], 1'b0, psf_r};
        `SRF_A_IC:     rd_nxt = {12'h000, ips_r, 1'b0, ige_r};
        `SRF_A_SC:     rd_nxt = sc_r;
        `SRF_A_VECTOR_PRIORITY_LOW:   rd_nxt = vector_priority_low_r;
        `SRF_A_VECTOR_PRIORITY_HIGH:   rd_nxt = vector_priority_high_r;
        `SRF_A_RIGHTS_FAULT_FLAGS:  rd_nxt = {8'h00, rights_fault_flags_r, 4'h0};
        `SRF_A_LOADER_REGION_BOUND:   rd_nxt = {7'h00, loader_region_bound_r};
        `SRF_A_APPLICATION_REGION_BOUND:   rd_nxt = {7'h00, application_region_bound_r};
        `SRF_A_CLOCK_DIVIDE_CONTROL:   rd_nxt = {8'h00, clock_divide_control_r};
        `SRF_A_WATCHDOG_CONTROL:   rd_nxt = {8'h00, watchdog_control_r};
        `SRF_A_ACC:    rd_nxt = acc_act;
        `SRF_A_ACC_AP: rd_nxt = acc_act;
        `SRF_A_IP:     rd_nxt = ip_r;
        `SRF_A_SP:     rd_nxt = {6'h00, sp_r};
        `SRF_A_IV:     rd_nxt = iv_r;
        `SRF_A_LC0:    rd_nxt = lc0_r;
        `SRF_A_LC1:    rd_nxt = lc1_r;
        `SRF_A_OFFS:   rd_nxt = {8'h00, offs_r};
        `SRF_A_DPC:    rd_nxt = {9'h000, dpc_r};
        `SRF_A_GR:     rd_nxt = {grh_r, grl_r};
        `SRF_A_GRL:    rd_nxt = {8'h00, grl_r};
        `SRF_A_BP:     rd_nxt = bp_r;
        `SRF_A_GRS:    rd_nxt = {grl_r, grh_r};
        `SRF_A_GRH:    rd_nxt = {8'h00, grh_r};
        `SRF_A_GENERAL_SIGN_EXTENDED:   rd_nxt = {{8{grl_r[7]}}, grl_r};
        `SRF_A_FP:     rd_nxt = bp_r + {8'h00, offs_r};
        `SRF_A_DP0:    rd_nxt = dp0_r;
        `SRF_A_DP1:    rd_nxt = dp1_r;
        `SRF_A_CP:     rd_nxt = cp_r;
        default:       rd_nxt = 16'h0000;
      endcase
    end
  end
  // Answer one cycle after the request
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rsp_r.vld  <= 1'b0;
      rsp_r.data <= 16'h0000;
    end
    else
    begin
      rsp_r.vld  <= src.vld;
      rsp_r.data <= rd_ok ? rd_nxt : 16'h0000;
    end
  end
endmodule

// ---- tb/srf_core_model.sv ----
`timescale 1ns/1ps
module srf_core_model (
  input  wire logic          mclk,
  input  srf_pkg::srf_rsp_t  rsp_r,
  output srf_pkg::srf_dst_t  dst,
  output srf_pkg::srf_src_t  src,
  output srf_pkg::srf_alu_t  alu
);
  import srf_pkg::*;
  // Idle buses from time zero
  initial
  begin
    dst = '0;
    src = '0;
    alu = '0;
  end
  // Move into a destination; np withholds the prefix on purpose
  task automatic wr(input logic [3:0] m, input logic [4:0] i, input logic [15:0] d,
                    input logic fa = 1'b0, input logic np = 1'b0);
    @(posedge mclk);
    dst <= '{1'b1, m, i, (i > 5'h07) && !np, fa, d};
    @(posedge mclk);
    dst <= '{1'b0, ~m, ~i, 1'b0, 1'b0, ~d};
    #1;
  endtask
  // Source read; a missing answer comes back unknown
  task automatic rd(input logic [3:0] m, input logic [4:0] i, output logic [15:0] q);
    @(posedge mclk);
    src <= '{1'b1, m, i, i > 5'h0f};
    @(posedge mclk);
    src <= '{1'b0, ~m, ~i, 1'b0};
    #1;
    q = (rsp_r.vld === 1'b1) ? rsp_r.data : 16'hxxxx;
  endtask
  // Completion pulse of an operation, with optional result write
  task automatic op(input logic w = 1'b0, input logic [15:0] r = 16'h0000);
    @(posedge mclk);
    alu <= '{1'b1, w, r};
    @(posedge mclk);
    alu <= '{1'b0, 1'b0, ~r};
    #1;
  endtask
endmodule

// ---- tb/srf_top_monitor.sv ----
`timescale 1ns/1ps
`include "srf_defs.svh"
module srf_monitor #(
  parameter logic [8:0] BOUND_RST = `SRF_BOUND_RST
) (
  input wire logic          mclk,
  input wire logic          rst,
  input wire logic          por,
  input srf_pkg::srf_dst_t  dst,
  input srf_pkg::srf_src_t  src,
  input srf_pkg::srf_alu_t  alu,
  input srf_pkg::srf_rsp_t  rsp_r,
  input wire logic [3:0]    ap_o,
  input wire logic [15:0]   acc_r
);
  import srf_pkg::*;
  logic [2:0] mod_sh_r;
  logic       dir_sh_r;
  logic       bnd_clean_r;
  logic [3:0] step_v;
  logic [3:0] ld_v;
  logic       ptr_wr;
  // Expected pointer after one step
  function automatic logic [3:0] step_f(input logic [3:0] a, input logic [2:0] m,
                                        input logic d);
    logic [3:0] k;
    k = (m == 3'h0) ? 4'h0 : (m == 3'h1) ? 4'h1 : (m == 3'h2) ? 4'h3 : (m == 3'h3) ? 4'h7 : 4'hf;
    return (a & ~k) | ((d ? a - 4'h1 : a + 4'h1) & k);
  endfunction
  // Shadow of the stepping controls
  always_ff @(posedge mclk)
    if (rst)
    begin
      mod_sh_r <= 3'h0;
      dir_sh_r <= 1'b0;
    end
    else if (ptr_wr && dst.idx[0])
    begin
      mod_sh_r <= dst.data[2:0];
      dir_sh_r <= dst.data[6];
    end
  // Bound registers untouched since reset
  always_ff @(posedge mclk)
    if (rst)
      bnd_clean_r <= 1'b1;
    else if (dst.vld && dst.mod == 4'h8 && dst.idx[4:1] == 4'h6)
      bnd_clean_r <= 1'b0;
  // Helper terms
  assign step_v = step_f(ap_o, mod_sh_r, dir_sh_r);
  assign ld_v   = dst.data[3:0];
  assign ptr_wr = dst.vld && dst.mod == 4'h8 && dst.idx[4:1] == 4'h0;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_ptr_load;
    ptr_wr && !dst.idx[0] && !(dst.from_acc && mod_sh_r != 3'h0);
  endsequence
  sequence s_ptr_read;
    src.vld && src.mod == 4'h8 && src.idx == 5'h00;
  endsequence
  sequence s_ctl_read;
    src.vld && src.mod == 4'h8 && src.idx == 5'h01;
  endsequence
  // Checks
  a_reset_clear: assert property ($fell(rst) |-> ap_o == 4'h0 && !rsp_r.vld)
    else $error("pointer or answer not cleared by reset");
  a_read_answer: assert property (src.vld |=> rsp_r.vld)
    else $error("read not answered next cycle");
  a_no_stray: assert property (!src.vld |=> !rsp_r.vld)
    else $error("answer without read");
  a_high_src_zero: assert property (src.vld && src.idx[4] |=> rsp_r.data == 16'h0000)
    else $error("high subindex read not zero");
  a_ptr_read: assert property (s_ptr_read |=> rsp_r.data == {12'h000, $past(ap_o)})
    else $error("pointer read wrong");
  a_ctl_read: assert property (s_ctl_read |=>
    rsp_r.data == {9'h000, $past(dir_sh_r), 3'h0, $past(mod_sh_r)})
    else $error("control read wrong");
  a_clear_wins: assert property (ptr_wr && dst.idx[0] && dst.data[7] |=> ap_o == 4'h0)
    else $error("clear did not zero pointer");
  a_ptr_load: assert property (s_ptr_load |=> ap_o == $past(ld_v))
    else $error("pointer load wrong");
  a_acc_step: assert property (
    ptr_wr && !dst.idx[0] && dst.from_acc && mod_sh_r != 3'h0 |=> ap_o == $past(step_v))
    else $error("load from accumulator did not step");
  a_op_step: assert property (alu.done && !ptr_wr |=> ap_o == $past(step_v))
    else $error("step after operation wrong");
  a_ptr_idle: assert property (!alu.done && !ptr_wr |=> $stable(ap_o))
    else $error("pointer moved while idle");
  a_bound_reset: assert property (
    src.vld && src.mod == 4'h8 && src.idx == 5'h0c && bnd_clean_r
    |=> rsp_r.data == {7'h00, BOUND_RST})
    else $error("bound reset value wrong");
endmodule
bind srf_top srf_monitor #(.BOUND_RST(BOUND_RST)) mon_u (.mclk(mclk), .rst(rst), .por(por),
  .dst(dst), .src(src), .alu(alu), .rsp_r(rsp_r), .ap_o(ap_o), .acc_r(acc_r));

// ---- tb/srf_top_tb.sv ----
`timescale 1ns/1ps
`include "srf_defs.svh"
module srf_top_tb;
  import srf_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        por = 1'b1;
  srf_dst_t    dst;
  srf_src_t    src;
  srf_alu_t    alu;
  srf_rsp_t    rsp_r;
  logic [3:0]  ap_o;
  logic [15:0] acc_r;
  int          err_count = 0;
  int          n_compared = 0;
  // Clock
  always #12.5 mclk = ~mclk;
  // Device and core model
  srf_top #(.BOUND_RST(9'h080)) dut_u (.mclk(mclk), .rst(rst), .por(por), .dst(dst),
    .src(src), .alu(alu), .rsp_r(rsp_r), .ap_o(ap_o), .acc_r(acc_r));
  srf_core_model core_u (.mclk(mclk), .rsp_r(rsp_r), .dst(dst), .src(src), .alu(alu));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Read and compare
  task automatic rdc(input logic [3:0] m, input logic [4:0] i, input logic [15:0] e);
    logic [15:0] q;
    core_u.rd(m, i, q);
    check(q, e);
  endtask
  // Reset for n cycles, power-on when p
  task automatic do_reset(input logic p, input int n);
    @(posedge mclk);
    rst <= 1'b1;
    por <= p;
    repeat (n) @(posedge mclk);
    rst <= 1'b0;
    #1;
  endtask
  // Expected pointer after one step
  function automatic logic [3:0] exp_step(input logic [3:0] a, input logic [2:0] m,
                                          input logic d);
    logic [3:0] k;
    k = (m == 3'h0) ? 4'h0 : (m == 3'h1) ? 4'h1 : (m == 3'h2) ? 4'h3 : (m == 3'h3) ? 4'h7 : 4'hf;
    return (a & ~k) | ((d ? a - 4'h1 : a + 4'h1) & k);
  endfunction
  // Prefix and decode limits
  task automatic t_prefix();
    core_u.wr(4'h8, 5'h0c, 16'h01ff, 1'b0, 1'b1);
    rdc(4'h8, 5'h0c, 16'h0080);
    core_u.wr(4'h8, 5'h0c, 16'h01ff);
    rdc(4'h8, 5'h0c, 16'h01ff);
    rdc(4'h8, 5'h10, 16'h0000);
    core_u.wr(4'h8, 5'h18, 16'h0003);
    core_u.wr(4'h7, 5'h00, 16'h0005);
    rdc(4'h8, 5'h00, 16'h0000);
    rdc(4'h7, 5'h00, 16'h0000);
  endtask
  // Working accumulator selection
  task automatic t_select();
    core_u.wr(4'h8, 5'h00, 16'hffff);
    rdc(4'h8, 5'h00, 16'h000f);
    core_u.wr(4'h9, 5'h05, 16'hbeef);
    core_u.wr(4'h8, 5'h00, 16'h0005);
    @(posedge mclk);
    #1;
    check(acc_r, 16'hbeef);
    core_u.op(1'b1, 16'h1234);
    @(posedge mclk);
    #1;
    check(acc_r, 16'h1234);
    rdc(4'h9, 5'h05, 16'h1234);
  endtask
  // Every modulus and direction, then load and clear cases
  task automatic t_step();
    logic [3:0] s;
    for (int m = 0; m < 8; m++)
      for (int d = 0; d < 2; d++)
      begin
        s = d[0] ? 4'h8 : 4'h7;
        core_u.wr(4'h8, 5'h00, {12'h000, s});
        core_u.wr(4'h8, 5'h01, {9'h000, d[0], 3'h0, m[2:0]});
        core_u.op();
        check({12'h000, ap_o}, {12'h000, exp_step(s, m[2:0], d[0])});
      end
    core_u.wr(4'h8, 5'h01, 16'h0004);
    core_u.wr(4'h8, 5'h00, 16'h0006);
    core_u.wr(4'h8, 5'h00, 16'h0003, 1'b1);
    check({12'h000, ap_o}, 16'h0007);
    core_u.wr(4'h8, 5'h01, 16'h00c4);
    check({12'h000, ap_o}, 16'h0000);
    rdc(4'h8, 5'h01, 16'h0044);
    core_u.wr(4'h8, 5'h01, 16'h0000);
    core_u.wr(4'h8, 5'h00, 16'h0003, 1'b1);
    check({12'h000, ap_o}, 16'h0003);
  endtask
  // Warm and power-on resets
  task automatic t_resets();
    core_u.wr(4'h8, 5'h08, 16'h0200);
    core_u.wr(4'h8, 5'h0f, 16'h00ff);
    core_u.wr(4'h8, 5'h01, 16'h0003);
    do_reset(1'b0, 2);
    rdc(4'h8, 5'h08, `SRF_SC_RST | 16'h0200);
    rdc(4'h8, 5'h0f, `SRF_WD_STATIC);
    rdc(4'h8, 5'h00, 16'h0000);
    rdc(4'h8, 5'h01, 16'h0000);
    rdc(4'h8, 5'h0c, 16'h0080);
    do_reset(1'b1, 2);
    rdc(4'h8, 5'h08, `SRF_SC_POR);
    rdc(4'h8, 5'h0f, 16'h0000);
    rdc(4'h8, 5'h0d, 16'h0080);
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_prefix();
    t_select();
    t_step();
    t_resets();
    complete_run();
  end
  // Watchdog against a hang
  initial
  begin
    #50000;
    err_count++;
    complete_run();
  end
endmodule
